// ==== core/ciel_pkg.sv ====
// Package: register map, field positions, codes and carrier types
// of the core interrupt/exception logic.
// Assumes a 32-bit APB register bus and one core clock.
package ciel_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_STATUS = 8'h00;
   localparam logic [7:0] OFF_REASON = 8'h04;
   localparam logic [7:0] OFF_MATCH = 8'h08;
   localparam logic [7:0] OFF_TALLY = 8'h0c;
   localparam logic [7:0] OFF_PERF = 8'h10;
   localparam logic [7:0] OFF_FPCSR = 8'h14;
   localparam logic [7:0] OFF_EVSTAT = 8'h18;
   localparam logic [7:0] OFF_EVMASK = 8'h1c;
   localparam logic [7:0] OFF_VECTOR = 8'h20;
   // Status register fields
   localparam int ST_GIE = 0;
   localparam int ST_MASK_LO = 8;
   localparam int ST_VEC_EN = 16;
   // Reason register fields
   localparam int RS_CODE_LO = 2;
   localparam int RS_PEND_LO = 8;
   localparam int RS_PERF_FLAG = 26;
   localparam int RS_TIMER_FLAG = 30;
   // Performance counter overflow bit
   localparam int PF_OVF = 31;
   // Floating-point control/status fields
   localparam int FP_EN_LO = 7;
   localparam int FP_CAUSE_LO = 12;
   localparam int FP_UNIMPL = 5;
   // Event status bits
   localparam int EV_INT = 0;
   localparam int EV_FPE = 1;
   localparam int EV_TIMER = 2;
   localparam int EV_PERF = 3;
   // Reset values
   localparam logic [31:0] STATUS_RST = 32'h0000_0000;
   localparam logic [31:0] MATCH_RST = 32'hffff_ffff;
   localparam logic [3:0] EVMASK_RST = 4'h0;
   // Reason codes
   localparam logic [4:0] CODE_INT = 5'h00;
   localparam logic [4:0] CODE_FPE = 5'h0f;
   // Vector layout
   localparam logic [31:0] VEC_BASE = 32'h8000_0000;
   localparam logic [31:0] VEC_COMMON = 32'h0000_0180;
   localparam logic [31:0] VEC_INT0 = 32'h0000_0200;
   localparam int VEC_SPACE_SH = 5;

   typedef struct packed {
      logic valid;
      logic [4:0] code;
      logic [31:0] vector;
   } ciel_exc_t;

   typedef struct packed {
      logic valid;
      logic [5:0] cause;
   } ciel_fp_ev_t;
endpackage

// ==== core/ciel_sync.sv ====
// Two-flip-flop synchroniser for a bundle of pin levels.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/100ps
module ciel_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Levels
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         dout <= '0;
      end else begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule

// ==== core/ciel_core.sv ====
// Interrupt and floating-point exception signalling of a processor core,
// with an APB register port and a level interrupt output.
// Assumes pipeline strobes and fp events come from pclk logic; pins async.
// Overview of operation
// - Floating-point exception raised unmasked, fp reason code, common vector.
// - Fp exception ends when software clears the active cause bits.
// - Interrupt exception taken when any of eight conditions is active, unmasked.
// - Each interrupt suppressed when its mask field bit is clear.
// - Clear global enable suppresses all eight interrupts.
// - Interrupt exception loads interrupt reason code into the reason field.
// - Legacy common vector, or vectored entry of highest unmasked pending interrupt.
// - Pending field shows live requests; several or none may be set.
// - Pending bit 7 ORs external line 5, timer match, perf overflow.
// - Timer and performance flags in reason register show those sources.
// - Software sets and clears pending bits 1 and 0.
// - Software interrupts are imprecise; taken a few cycles later.
// - A write to the timer match register clears timer interrupt, unless a timer match hits in the same cycle.
// - Writing zero to overflow bit 31 clears performance interrupt.
// - Cold and soft reset clear external requests in pending 2 to 6.
`timescale 1ns/100ps
module ciel_core (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins
   input wire logic [5:0] ext_irq,
   input wire logic soft_reset,
   // Coprocessor and counters
   input wire ciel_pkg::ciel_fp_ev_t fp_ev,
   input wire logic perf_overflow,
   // Pipeline
   input wire logic exc_take,
   output ciel_pkg::ciel_exc_t exc,
   // Interrupt
   output logic irq
);
   logic [5:0] ext_s;
   logic soft_s;
   logic [4:0] ext_q;
   logic [31:0] status_q;
   logic [1:0] sw_q;
   logic [4:0] reason_q;
   logic [31:0] match_q;
   logic [31:0] tally_q;
   logic timer_q;
   logic perf_q;
   logic [5:0] cause_q;
   logic [4:0] fpen_q;
   logic [3:0] evstat_q;
   logic [3:0] evmask_q;
   logic [31:0] vec_q;
   logic [7:0] pend;
   logic [7:0] active;
   logic gie;
   logic [7:0] mask;
   logic int_req;
   logic fp_exc;
   logic wr;
   logic rd_setup;
   logic mapped;
   logic [2:0] top_idx;
   logic [31:0] next_vec;
   logic [3:0] ev_set;
   logic timer_hit;
   logic [31:0] reason_rd;

   ciel_sync #(.W(7)) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .din({soft_reset, ext_irq}),
      .dout({soft_s, ext_s})
   );

   // APB decode: zero wait states, error on unmapped offsets
   assign wr = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign pready = 1'b1;
   always_comb begin
      mapped = 1'b0;
      unique case (paddr)
         ciel_pkg::OFF_STATUS, ciel_pkg::OFF_REASON, ciel_pkg::OFF_MATCH,
         ciel_pkg::OFF_TALLY, ciel_pkg::OFF_PERF, ciel_pkg::OFF_FPCSR,
         ciel_pkg::OFF_EVSTAT, ciel_pkg::OFF_EVMASK,
         ciel_pkg::OFF_VECTOR: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !mapped;

   // External requests 0 to 4 follow the pin, dropped by soft reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_q <= '0;
      end else if (soft_s) begin
         ext_q <= '0;
      end else begin
         ext_q <= ext_s[4:0];
      end
   end

   // Status register: global enable, mask field, vectored mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q <= ciel_pkg::STATUS_RST;
      end else if (wr && paddr == ciel_pkg::OFF_STATUS) begin
         status_q <= pwdata & 32'h0001_ff01;
      end
   end
   assign gie = status_q[ciel_pkg::ST_GIE];
   assign mask = status_q[ciel_pkg::ST_MASK_LO +: 8];

   // Software interrupt bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_q <= '0;
      end else if (wr && paddr == ciel_pkg::OFF_REASON) begin
         sw_q <= pwdata[ciel_pkg::RS_PEND_LO +: 2];
      end
   end

   // Timer: free-running tally against match value
   assign timer_hit = tally_q == match_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tally_q <= '0;
      end else if (wr && paddr == ciel_pkg::OFF_TALLY) begin
         tally_q <= pwdata;
      end else begin
         tally_q <= tally_q + 32'h0000_0001;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_q <= ciel_pkg::MATCH_RST;
      end else if (wr && paddr == ciel_pkg::OFF_MATCH) begin
         match_q <= pwdata;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_q <= 1'b0;
      end else if (timer_hit) begin
         timer_q <= 1'b1;
      end else if (wr && paddr == ciel_pkg::OFF_MATCH) begin
         timer_q <= 1'b0;
      end
   end

   // Performance counter overflow flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         perf_q <= 1'b0;
      end else if (perf_overflow) begin
         perf_q <= 1'b1;
      end else if (wr && paddr == ciel_pkg::OFF_PERF) begin
         perf_q <= pwdata[ciel_pkg::PF_OVF];
      end
   end

   // Floating-point cause and enables; new causes win over a write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause_q <= '0;
         fpen_q <= '0;
      end else begin
         if (wr && paddr == ciel_pkg::OFF_FPCSR) begin
            cause_q <= pwdata[ciel_pkg::FP_CAUSE_LO +: 6] | ({6{fp_ev.valid}} & fp_ev.cause);
            fpen_q <= pwdata[ciel_pkg::FP_EN_LO +: 5];
         end else if (fp_ev.valid) begin
            cause_q <= cause_q | fp_ev.cause;
         end
      end
   end
   assign fp_exc = cause_q[ciel_pkg::FP_UNIMPL] || |(cause_q[4:0] & fpen_q);

   // Live pending field and request
   assign pend = {ext_s[5] | timer_q | perf_q, ext_q, sw_q};
   assign active = pend & mask;
   assign int_req = gie && |active;

   always_comb begin
      top_idx = 3'd0;
      for (int i = 0; i < 8; i++) begin
         if (active[i]) begin
            top_idx = 3'(i);
         end
      end
   end

   always_comb begin
      if (fp_exc) begin
         next_vec = ciel_pkg::VEC_BASE + ciel_pkg::VEC_COMMON;
      end else if (status_q[ciel_pkg::ST_VEC_EN]) begin
         next_vec = ciel_pkg::VEC_BASE + ciel_pkg::VEC_INT0
            + ({29'h0, top_idx} << ciel_pkg::VEC_SPACE_SH);
      end else begin
         next_vec = ciel_pkg::VEC_BASE + ciel_pkg::VEC_COMMON;
      end
   end

   // Registered request to the pipeline; fp has priority
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exc <= '0;
      end else begin
         exc.valid <= fp_exc || int_req;
         exc.code <= fp_exc ? ciel_pkg::CODE_FPE : ciel_pkg::CODE_INT;
         exc.vector <= next_vec;
      end
   end

   // Reason field and vector loaded when the pipeline takes it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reason_q <= '0;
         vec_q <= '0;
      end else if (exc_take && exc.valid) begin
         reason_q <= exc.code;
         vec_q <= exc.vector;
      end
   end

   // Sticky events, write one to clear, set wins
   assign ev_set = {perf_overflow, timer_hit,
                    exc_take && exc.valid && exc.code == ciel_pkg::CODE_FPE,
                    exc_take && exc.valid && exc.code == ciel_pkg::CODE_INT};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evstat_q <= '0;
      end else if (wr && paddr == ciel_pkg::OFF_EVSTAT) begin
         evstat_q <= (evstat_q & ~pwdata[3:0]) | ev_set;
      end else begin
         evstat_q <= evstat_q | ev_set;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evmask_q <= ciel_pkg::EVMASK_RST;
      end else if (wr && paddr == ciel_pkg::OFF_EVMASK) begin
         evmask_q <= pwdata[3:0];
      end
   end
   assign irq = |(evstat_q & evmask_q);

   // Read data captured in the setup cycle
   always_comb begin
      reason_rd = '0;
      reason_rd[ciel_pkg::RS_CODE_LO +: 5] = reason_q;
      reason_rd[ciel_pkg::RS_PEND_LO +: 8] = pend;
      reason_rd[ciel_pkg::RS_PERF_FLAG] = perf_q;
      reason_rd[ciel_pkg::RS_TIMER_FLAG] = timer_q;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (rd_setup) begin
         unique case (paddr)
            ciel_pkg::OFF_STATUS: prdata <= status_q;
            ciel_pkg::OFF_REASON: prdata <= reason_rd;
            ciel_pkg::OFF_MATCH: prdata <= match_q;
            ciel_pkg::OFF_TALLY: prdata <= tally_q;
            ciel_pkg::OFF_PERF: prdata <= {perf_q, 31'h0};
            ciel_pkg::OFF_FPCSR: prdata <= {14'h0, cause_q, fpen_q, 7'h0};
            ciel_pkg::OFF_EVSTAT: prdata <= {28'h0, evstat_q};
            ciel_pkg::OFF_EVMASK: prdata <= {28'h0, evmask_q};
            ciel_pkg::OFF_VECTOR: prdata <= vec_q;
            default: prdata <= '0;
         endcase
      end
   end

   // Checks
   fp_raise_a: assert property (@(posedge pclk) disable iff (!presetn)
      fp_exc |=> exc.valid && exc.code == ciel_pkg::CODE_FPE
         && exc.vector == ciel_pkg::VEC_BASE + ciel_pkg::VEC_COMMON)
      else $error("fp exception not raised");

   fp_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr && paddr == ciel_pkg::OFF_FPCSR && !fp_ev.valid
         && pwdata[ciel_pkg::FP_CAUSE_LO +: 6] == 6'h00 |=> !fp_exc)
      else $error("fp cause not cleared");

   int_take_a: assert property (@(posedge pclk) disable iff (!presetn)
      !fp_exc && gie && |(pend & mask) |=> exc.valid
         && exc.code == ciel_pkg::CODE_INT)
      else $error("interrupt not requested");

   mask_block_a: assert property (@(posedge pclk) disable iff (!presetn)
      (pend & mask) == 8'h00 && !fp_exc |=> !exc.valid)
      else $error("masked interrupt requested");

   gie_block_a: assert property (@(posedge pclk) disable iff (!presetn)
      !gie && !fp_exc |=> !exc.valid)
      else $error("interrupt with global enable clear");

   reason_load_a: assert property (@(posedge pclk) disable iff (!presetn)
      exc_take && exc.valid |=> reason_q == $past(exc.code)
         && vec_q == $past(exc.vector))
      else $error("reason not loaded");

   legacy_vec_a: assert property (@(posedge pclk) disable iff (!presetn)
      exc.valid && exc.code == ciel_pkg::CODE_INT && !$past(status_q[ciel_pkg::ST_VEC_EN])
         |-> exc.vector == ciel_pkg::VEC_BASE + ciel_pkg::VEC_COMMON)
      else $error("legacy vector wrong");

   timer_pend_a: assert property (@(posedge pclk) disable iff (!presetn)
      timer_hit |=> pend[7] && timer_q)
      else $error("timer match not pending");

   sw_pend_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr && paddr == ciel_pkg::OFF_REASON |=> pend[1:0] == $past(pwdata[9:8]))
      else $error("software pending not written");

   match_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr && paddr == ciel_pkg::OFF_MATCH && !timer_hit |=> !timer_q)
      else $error("timer flag not cleared");

   perf_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr && paddr == ciel_pkg::OFF_PERF && !pwdata[31] && !perf_overflow
         |=> !perf_q)
      else $error("perf flag not cleared");

   soft_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
      soft_s |=> pend[6:2] == 5'h00)
      else $error("soft reset kept external requests");

   irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
      |(ev_set & evmask_q) && !(wr && paddr == ciel_pkg::OFF_EVMASK) |=> irq)
      else $error("irq output wrong");

   fp_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
      fp_exc ##1 exc_take ##1 !fp_exc);
   vec_int_c: cover property (@(posedge pclk) disable iff (!presetn)
      exc.valid && status_q[16] && exc.code == ciel_pkg::CODE_INT);
   timer_int_c: cover property (@(posedge pclk) disable iff (!presetn)
      timer_q && int_req);
   soft_rst_c: cover property (@(posedge pclk) disable iff (!presetn)
      |ext_q ##1 soft_s);
endmodule

// ==== dv/ciel_src_model.sv ====
// Model of the far side: interrupt pins, soft reset pin, fp coprocessor
// events and performance counter overflow pulses. Driven by bench tasks.
`timescale 1ns/100ps
module ciel_src_model (
   // Clock
   input wire logic pclk,
   // Toward the core
   output logic [5:0] ext_irq,
   output logic soft_reset,
   output ciel_pkg::ciel_fp_ev_t fp_ev,
   output logic perf_overflow
);
   initial begin
      ext_irq = 6'h00;
      soft_reset = 1'b0;
      fp_ev = '0;
      perf_overflow = 1'b0;
   end

   // Pin stays up until the source itself drops its condition
   task automatic pin(input int i, input logic lvl);
      @(posedge pclk);
      ext_irq[i] <= lvl;
   endtask

   task automatic sreset(input logic lvl);
      @(posedge pclk);
      soft_reset <= lvl;
   endtask

   // Cause lines carry junk outside the valid cycle
   task automatic fp_pulse(input logic [5:0] c);
      @(posedge pclk);
      fp_ev <= {1'b1, c};
      @(posedge pclk);
      fp_ev <= {1'b0, ~c};
   endtask

   task automatic perf_pulse();
      @(posedge pclk);
      perf_overflow <= 1'b1;
      @(posedge pclk);
      perf_overflow <= 1'b0;
   endtask
endmodule

// ==== dv/testbench.sv ====
// Self-checking bench for the interrupt/exception core over APB.
// Assumes the source model drives pins and the bench plays the pipeline.
`timescale 1ns/100ps
module testbench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, exc_take;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [5:0] ext_irq;
   logic soft_reset, perf_overflow;
   ciel_pkg::ciel_fp_ev_t fp_ev;
   ciel_pkg::ciel_exc_t exc;
   int err_total = 0;
   int checks = 0;
   localparam logic [31:0] VC = ciel_pkg::VEC_BASE + ciel_pkg::VEC_COMMON;
   localparam logic [31:0] VI = ciel_pkg::VEC_BASE + ciel_pkg::VEC_INT0;

   ciel_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_irq(ext_irq), .soft_reset(soft_reset),
      .fp_ev(fp_ev), .perf_overflow(perf_overflow), .exc_take(exc_take), .exc(exc),
      .irq(irq));
   ciel_src_model u_src (.pclk(pclk), .ext_irq(ext_irq), .soft_reset(soft_reset),
      .fp_ev(fp_ev), .perf_overflow(perf_overflow));

   always #20 pclk = ~pclk;

   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      logic err;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         err_total++;
         print_verdict();
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("pslverr", {31'h0, err}, {31'h0, a > ciel_pkg::OFF_VECTOR});
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      apb(1'b0, a, 32'h0, q);
      chk($sformatf("reg_%h", a), q & m, e);
   endtask

   // Waits a bounded time for exc.valid to reach v, then checks it
   task automatic exp_exc(input logic v, input logic [4:0] c, input logic [31:0] vec);
      int n;
      for (n = 0; n < 12; n++) begin
         @(posedge pclk);
         #1;
         if (exc.valid === v) break;
      end
      if (n == 12) begin
         err_total++;
         print_verdict();
      end
      chk("exc_valid", {31'h0, exc.valid}, {31'h0, v});
      if (v) begin
         chk("exc_code", {27'h0, exc.code}, {27'h0, c});
         chk("exc_vector", exc.vector, vec);
      end
   endtask

   task automatic chk_irq(input logic e);
      #1;
      chk("irq", {31'h0, irq}, {31'h0, e});
   endtask

   task automatic endtest(input string nm);
      $display("Test %s done, mismatches so far %0d", nm, err_total);
   endtask

   initial begin
      int pb;
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      exc_take = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      rd(ciel_pkg::OFF_STATUS, 32'hffff_ffff, ciel_pkg::STATUS_RST);
      rd(ciel_pkg::OFF_MATCH, 32'hffff_ffff, ciel_pkg::MATCH_RST);
      rd(ciel_pkg::OFF_REASON, 32'hffff_ffff, 32'h0);
      rd(8'h40, 32'hffff_ffff, 32'h0);
      wr(8'h44, 32'hffff_ffff);
      endtest("reset");
      // Software bits, masking, vectored priority
      wr(ciel_pkg::OFF_STATUS, 32'h0000_0101);
      wr(ciel_pkg::OFF_REASON, 32'h0000_0100);
      exp_exc(1'b1, ciel_pkg::CODE_INT, VC);
      rd(ciel_pkg::OFF_REASON, 32'h0000_ff00, 32'h0000_0100);
      wr(ciel_pkg::OFF_STATUS, 32'h0000_0001);
      exp_exc(1'b0, 5'h0, 32'h0);
      wr(ciel_pkg::OFF_STATUS, 32'h0000_0100);
      exp_exc(1'b0, 5'h0, 32'h0);
      wr(ciel_pkg::OFF_STATUS, 32'h0001_0301);
      wr(ciel_pkg::OFF_REASON, 32'h0000_0300);
      exp_exc(1'b1, ciel_pkg::CODE_INT, VI + 32'h20);
      rd(ciel_pkg::OFF_REASON, 32'h0000_ff00, 32'h0000_0300);
      @(posedge pclk);
      exc_take <= 1'b1;
      @(posedge pclk);
      exc_take <= 1'b0;
      rd(ciel_pkg::OFF_VECTOR, 32'hffff_ffff, VI + 32'h20);
      rd(ciel_pkg::OFF_REASON, 32'h0000_007c, {25'h0, ciel_pkg::CODE_INT, 2'b00});
      rd(ciel_pkg::OFF_EVSTAT, 32'h0000_0001, 32'h1);
      wr(ciel_pkg::OFF_EVSTAT, 32'h0000_0001);
      wr(ciel_pkg::OFF_REASON, 32'h0);
      exp_exc(1'b0, 5'h0, 32'h0);
      rd(ciel_pkg::OFF_REASON, 32'h0000_ff00, 32'h0);
      endtest("software");
      // External lines, soft reset
      wr(ciel_pkg::OFF_STATUS, 32'h0001_ff01);
      for (int i = 0; i < 6; i++) begin
         pb = (i == 5) ? 7 : i + 2;
         u_src.pin(i, 1'b1);
         exp_exc(1'b1, ciel_pkg::CODE_INT, VI + (pb << ciel_pkg::VEC_SPACE_SH));
         rd(ciel_pkg::OFF_REASON, 32'h0000_ff00, 32'h1 << (8 + pb));
         u_src.sreset(1'b1);
         exp_exc(i == 5, ciel_pkg::CODE_INT, VI + 32'he0);
         u_src.sreset(1'b0);
         exp_exc(1'b1, ciel_pkg::CODE_INT, VI + (pb << ciel_pkg::VEC_SPACE_SH));
         u_src.pin(i, 1'b0);
         exp_exc(1'b0, 5'h0, 32'h0);
      end
      endtest("external");
      // Timer match
      wr(ciel_pkg::OFF_STATUS, 32'h0000_8001);
      wr(ciel_pkg::OFF_EVMASK, 32'h4);
      wr(ciel_pkg::OFF_TALLY, 32'h0);
      wr(ciel_pkg::OFF_MATCH, 32'h40);
      chk_irq(1'b0);
      repeat (80) @(posedge pclk);
      exp_exc(1'b1, ciel_pkg::CODE_INT, VC);
      rd(ciel_pkg::OFF_REASON, 32'h4000_8000, 32'h4000_8000);
      chk_irq(1'b1);
      wr(ciel_pkg::OFF_EVSTAT, 32'h4);
      chk_irq(1'b0);
      wr(ciel_pkg::OFF_MATCH, 32'hffff_ffff);
      rd(ciel_pkg::OFF_REASON, 32'h4000_8000, 32'h0);
      exp_exc(1'b0, 5'h0, 32'h0);
      endtest("timer");
      // Performance overflow
      wr(ciel_pkg::OFF_EVMASK, 32'h8);
      u_src.perf_pulse();
      rd(ciel_pkg::OFF_PERF, 32'h8000_0000, 32'h8000_0000);
      rd(ciel_pkg::OFF_REASON, 32'h0400_8000, 32'h0400_8000);
      exp_exc(1'b1, ciel_pkg::CODE_INT, VC);
      chk_irq(1'b1);
      wr(ciel_pkg::OFF_EVMASK, 32'h0);
      chk_irq(1'b0);
      wr(ciel_pkg::OFF_PERF, 32'h0);
      rd(ciel_pkg::OFF_REASON, 32'h0400_8000, 32'h0);
      exp_exc(1'b0, 5'h0, 32'h0);
      wr(ciel_pkg::OFF_EVSTAT, 32'h8);
      rd(ciel_pkg::OFF_EVSTAT, 32'hf, 32'h0);
      endtest("perf");
      // Floating point, global enable off
      wr(ciel_pkg::OFF_STATUS, 32'h0);
      wr(ciel_pkg::OFF_FPCSR, 32'h80);
      u_src.fp_pulse(6'h01);
      exp_exc(1'b1, ciel_pkg::CODE_FPE, VC);
      rd(ciel_pkg::OFF_FPCSR, 32'h0003_f000, 32'h0000_1000);
      @(posedge pclk);
      exc_take <= 1'b1;
      @(posedge pclk);
      exc_take <= 1'b0;
      rd(ciel_pkg::OFF_REASON, 32'h0000_007c, {25'h0, ciel_pkg::CODE_FPE, 2'b00});
      rd(ciel_pkg::OFF_EVSTAT, 32'h0000_0002, 32'h2);
      wr(ciel_pkg::OFF_FPCSR, 32'h80);
      exp_exc(1'b0, 5'h0, 32'h0);
      wr(ciel_pkg::OFF_FPCSR, 32'h0);
      u_src.fp_pulse(6'h20);
      exp_exc(1'b1, ciel_pkg::CODE_FPE, VC);
      wr(ciel_pkg::OFF_FPCSR, 32'h0);
      exp_exc(1'b0, 5'h0, 32'h0);
      endtest("float");
      // Interrupt taken after an fp one: reason code reloaded
      wr(ciel_pkg::OFF_STATUS, 32'h0000_0101);
      wr(ciel_pkg::OFF_REASON, 32'h0000_0100);
      exp_exc(1'b1, ciel_pkg::CODE_INT, VC);
      @(posedge pclk);
      exc_take <= 1'b1;
      @(posedge pclk);
      exc_take <= 1'b0;
      rd(ciel_pkg::OFF_REASON, 32'h0000_007c, {25'h0, ciel_pkg::CODE_INT, 2'b00});
      rd(ciel_pkg::OFF_VECTOR, 32'hffff_ffff, VC);
      wr(ciel_pkg::OFF_REASON, 32'h0);
      endtest("reload");
      print_verdict();
   end
endmodule
